// ---- verilog/pmic_spi_register_bank.sv ----
// register bank of the power manager behind its serial link
`include "pmic_regs_map.svh"
module pmic_spi_register_bank
  import pmic_regs_pkg::*;
#(
  parameter logic [7:0] IDENTITY_VALUE = 8'h02 // arbitrary neutral identity
)(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ncs_i,
  input  wire logic       sck_i,
  input  wire logic       sdi_i,
  input  dev_state_t      dev_state_i,
  input  wire logic       cfg_lock_i,
  input  wire logic [7:0] status_i,
  input  wire logic [3:0] analog_cond_i,
  output logic            sdo_o,
  output logic            sdo_oe_o,
  output logic            enable_drive_or_irq_pin_o,
  output logic            enable_drive_control_bit_o,
  output logic            safe_request_o,
  output logic [7:0]      config_checksum_guard_o
);

  localparam int NR = `NUM_REGS;
  localparam int NC = `NUM_REGS - `FIRST_CFG_IDX;

  // ========================================================================
  // constant tables per register
  localparam logic [7:0] RST_TAB [NR] = '{
    `RST_REVISION, 8'h00, `RST_STATUS_ONE, `RST_CONFIG_ONE, `RST_CONFIG_TWO,
    `RST_SAFETY_FOUR, `RST_SAFETY_FIVE, `RST_EXT_MON_ONE, `RST_WATCHDOG};
  localparam logic [7:0] MASK_TAB [NR] = '{
    `MASK_REVISION, `MASK_IDENTITY, `MASK_STATUS_ONE, `MASK_CONFIG_ONE,
    `MASK_CONFIG_TWO, `MASK_SAFETY_FOUR, `MASK_SAFETY_FIVE, `MASK_EXT_MON_ONE,
    `MASK_WATCHDOG};

  // ========================================================================
  // link receiver
  logic       active;
  logic       start;
  logic       rise;
  logic       cmd_valid;
  logic       done;
  logic [4:0] bit_cnt;
  spi_frame_t frame;

  spi_frame_rx u_rx (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ncs_i       (ncs_i),
    .sck_i       (sck_i),
    .sdi_i       (sdi_i),
    .active_o    (active),
    .start_o     (start),
    .rise_o      (rise),
    .cmd_valid_o (cmd_valid),
    .done_o      (done),
    .bit_cnt_o   (bit_cnt),
    .frame_o     (frame)
  );

  // ========================================================================
  // state decode
  // the link answers only in DIAGNOSTIC, ACTIVE and SAFE
  wire link_on   = !(dev_state_i inside {ST_OFF, ST_INIT, ST_RESET});
  wire in_reset  = (dev_state_i == ST_RESET);
  wire cfg_open  = (dev_state_i == ST_DIAGNOSTIC) && !cfg_lock_i;

  // ========================================================================
  // command decode, reads and writes in separate families
  // a write aimed at a read-only entry is undefined and flags the frame
  wire [3:0] cmd_fam = frame.cmd[7:4];
  wire [3:0] cmd_idx = frame.cmd[3:0];
  wire idx_ok   = (cmd_idx < 4'(NR));
  wire is_read  = (cmd_fam == `CMD_RD_FAMILY) && idx_ok;
  wire is_write = (cmd_fam == `CMD_WR_FAMILY) && idx_ok &&
                  (cmd_idx >= 4'(`FIRST_CFG_IDX));
  wire cmd_bad  = !(is_read || is_write);
  wire frame_ok = frame.len_ok && !cmd_bad;
  wire wr_take  = done && link_on && frame_ok && is_write && cfg_open;

  // ========================================================================
  // register storage and next values
  // a host write and a fault in one cycle: the fault's clear wins
  logic [7:0] regs      [NR];
  logic [7:0] next_regs [NR];
  logic [7:0] wr_byte;
  wire  fault     = |(regs[`IDX_CONFIG_TWO][3:0] & analog_cond_i);
  wire  wd_change = wr_take && (cmd_idx == `IDX_WATCHDOG) &&
                    ((frame.data & MASK_TAB[`IDX_WATCHDOG]) != regs[`IDX_WATCHDOG]);
  assign wr_byte  = frame.data;

  genvar i;
  for (i = 0; i < NR; i++) begin : g_reg
    logic hit;
    logic reload;
    logic [7:0] held;
    assign hit = wr_take && (cmd_idx == 4'(i));
    // entries that also reload in RESET or on a watchdog change
    if (i == `IDX_SAFETY_FOUR) begin : g_r4
      assign reload = in_reset;
    end else if (i == `IDX_SAFETY_FIVE) begin : g_r5
      assign reload = in_reset || wd_change;
    end else begin : g_rn
      assign reload = 1'b0;
    end
    // write merge, only the configuration entries are writable
    if (i == `IDX_STATUS_ONE) begin : g_st
      assign held = status_i & MASK_TAB[i];
    end else if (i >= `FIRST_CFG_IDX) begin : g_cf
      assign held = hit ? (wr_byte & MASK_TAB[i]) : regs[i];
    end else begin : g_ro
      assign held = regs[i];
    end
    // enable-drive bit is cleared by an enabled fault, over any write
    if (i == `IDX_CONFIG_ONE) begin : g_en
      assign next_regs[i] = fault ? (held & ~(8'h01 << `POS_ENDRV_BIT)) : held;
    end else begin : g_pl
      assign next_regs[i] = reload ? RST_TAB[i] : held;
    end
    // power-on defaults, identity taken from the parameter
    // status entry copies its live input every cycle, no write path
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        regs[i] <= (i == `IDX_IDENTITY) ? (IDENTITY_VALUE & MASK_TAB[i])
                                        : RST_TAB[i];
      end else begin
        regs[i] <= next_regs[i];
      end
    end
  end

  // ========================================================================
  // checksum over every configuration entry
  // recomputed every cycle, so it trails a write by one cycle
  function automatic logic [7:0] cfg_crc(input logic [8*NC-1:0] bytes);
    logic [7:0] c;
    c = `CRC_INIT;
    for (int b = 8*NC-1; b >= 0; b--) begin
      c = (c[7] ^ bytes[b]) ? ({c[6:0], 1'b0} ^ `CRC_POLY) : {c[6:0], 1'b0};
    end
    return ~c;
  endfunction : cfg_crc

  logic [8*NC-1:0] cfg_bytes;
  for (i = 0; i < NC; i++) begin : g_pack
    assign cfg_bytes[8*(NC-i)-1 -: 8] = regs[i + `FIRST_CFG_IDX];
  end

  // ========================================================================
  // response: status byte then read data, zeros while the link is off
  logic       bad_prev;
  logic [15:0] resp;
  wire [7:0] stat_byte = link_on ? (8'(bad_prev) << `POS_STAT_INVALID) : 8'h00;
  wire [7:0] rd_data   = (link_on && is_read) ? (regs[cmd_idx] & MASK_TAB[cmd_idx])
                                              : 8'h00;
  wire [3:0] out_pos   = 4'(5'd15 - bit_cnt);

  // invalid-frame flag for the next status byte, cleared in RESET
  // a frame met while the link is off leaves the flag alone
  always_ff @(posedge clk_i) begin
    if (rst_i || in_reset) begin
      bad_prev <= 1'b0;
    end else if (done && link_on) begin
      bad_prev <= !frame_ok;
    end
  end

  // response word build-up and serial output on rising clock edges
  // the first rise carries no new bit, status bit seven already stands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resp     <= 16'h0000;
      sdo_o    <= 1'b0;
      sdo_oe_o <= 1'b0;
    end else begin
      sdo_oe_o <= active;
      if (start) begin
        resp  <= {stat_byte, 8'h00};
        sdo_o <= stat_byte[7];
      end else begin
        if (cmd_valid) resp[7:0] <= rd_data;
        if (rise && bit_cnt != 5'd0) begin
          sdo_o <= (bit_cnt < `FRAME_BITS) ? resp[out_pos] : 1'b0;
        end
      end
    end
  end

  // ========================================================================
  // fault path and checksum outputs
  // pin and bit share one source so they can never disagree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_drive_or_irq_pin_o  <= 1'b0;
      enable_drive_control_bit_o <= 1'b0;
      safe_request_o             <= 1'b0;
      config_checksum_guard_o    <= 8'h00;
    end else begin
      enable_drive_or_irq_pin_o  <= next_regs[`IDX_CONFIG_ONE][`POS_ENDRV_BIT];
      enable_drive_control_bit_o <= next_regs[`IDX_CONFIG_ONE][`POS_ENDRV_BIT];
      safe_request_o             <= fault;
      config_checksum_guard_o    <= cfg_crc(cfg_bytes);
    end
  end

endmodule : pmic_spi_register_bank

// ---- inc/pmic_regs_map.svh ----
// register bank offsets, field positions, reset values and codes
`ifndef PMIC_REGS_MAP_SVH
`define PMIC_REGS_MAP_SVH

// ==========================================================================
// register indexes (low nibble of a command)
`define IDX_REVISION        4'h0
`define IDX_IDENTITY        4'h1
`define IDX_STATUS_ONE      4'h2
`define IDX_CONFIG_ONE      4'h3
`define IDX_CONFIG_TWO      4'h4
`define IDX_SAFETY_FOUR     4'h5
`define IDX_SAFETY_FIVE     4'h6
`define IDX_EXT_MON_ONE     4'h7
`define IDX_WATCHDOG        4'h8
`define NUM_REGS            9
`define FIRST_CFG_IDX       3

// ==========================================================================
// command families (high nibble of a command)
`define CMD_RD_FAMILY       4'h0
`define CMD_WR_FAMILY       4'h8

// ==========================================================================
// reset values
`define RST_REVISION        8'h10
`define RST_STATUS_ONE      8'h00
`define RST_CONFIG_ONE      8'h01
`define RST_CONFIG_TWO      8'h00
`define RST_SAFETY_FOUR     8'h00
`define RST_SAFETY_FIVE     8'h00
`define RST_EXT_MON_ONE     8'h00
`define RST_WATCHDOG        8'h00

// ==========================================================================
// implemented-bit masks, unused bits read as zero
`define MASK_REVISION       8'hff
`define MASK_IDENTITY       8'h03
`define MASK_STATUS_ONE     8'hff
`define MASK_CONFIG_ONE     8'hff
`define MASK_CONFIG_TWO     8'h0f
`define MASK_SAFETY_FOUR    8'hff
`define MASK_SAFETY_FIVE    8'hff
`define MASK_EXT_MON_ONE    8'h7f
`define MASK_WATCHDOG       8'hff

// ==========================================================================
// field positions and frame figures
`define POS_ENDRV_BIT       0
`define POS_STAT_INVALID    0
`define FRAME_BITS          5'd16
`define CMD_BITS            5'd8
`define CRC_INIT            8'hff
`define CRC_POLY            8'h07

`endif

// ---- inc/pmic_regs_pkg.sv ----
// types shared by the register bank and its link receiver
package pmic_regs_pkg;

  // ========================================================================
  // device operating states as seen by the bank
  typedef enum logic [2:0] {
    ST_OFF        = 3'h0,
    ST_INIT       = 3'h1,
    ST_RESET      = 3'h3,
    ST_DIAGNOSTIC = 3'h2,
    ST_ACTIVE     = 3'h6,
    ST_SAFE       = 3'h7
  } dev_state_t;

  // ========================================================================
  // one received serial frame
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] data;
    logic       len_ok;
  } spi_frame_t;

endpackage : pmic_regs_pkg

// ---- verilog/spi_frame_rx.sv ----
// serial link pin sampler and frame receiver
`include "pmic_regs_map.svh"
module spi_frame_rx
  import pmic_regs_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ncs_i,
  input  wire logic       sck_i,
  input  wire logic       sdi_i,
  output logic            active_o,
  output logic            start_o,
  output logic            rise_o,
  output logic            cmd_valid_o,
  output logic            done_o,
  output logic [4:0]      bit_cnt_o,
  output spi_frame_t      frame_o
);

  // ========================================================================
  // three-stage sampling, a change counts when stages two and three agree
  logic [2:0] pins;
  logic [2:0] ff1;
  logic [2:0] ff2;
  logic [2:0] ff3;
  logic [2:0] filt;
  assign pins = {ncs_i, sck_i, sdi_i};

  genvar g;
  for (g = 0; g < 3; g++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        // idle levels: select high, clock and data low, so no false edge
        ff1[g]  <= (g == 2);
        ff2[g]  <= (g == 2);
        ff3[g]  <= (g == 2);
        filt[g] <= (g == 2);
      end else begin
        ff1[g] <= pins[g];
        ff2[g] <= ff1[g];
        ff3[g] <= ff2[g];
        if (ff2[g] == ff3[g]) filt[g] <= ff3[g];
      end
    end
  end

  // edge decode from the filtered levels
  wire ncs_now  = (ff2[2] == ff3[2]) ? ff3[2] : filt[2];
  wire sck_now  = (ff2[1] == ff3[1]) ? ff3[1] : filt[1];
  wire ncs_fall = filt[2] & ~ncs_now;
  wire ncs_rise = ~filt[2] & ncs_now;
  wire sck_fall = filt[1] & ~sck_now & ~filt[2];
  wire sck_rise = ~filt[1] & sck_now & ~filt[2];
  wire [4:0] cnt_inc = (bit_cnt_o == 5'h1f) ? bit_cnt_o : bit_cnt_o + 5'd1;

  // ========================================================================
  // bit counting and shifting on falling clock edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_o    <= 1'b0;
      start_o     <= 1'b0;
      rise_o      <= 1'b0;
      cmd_valid_o <= 1'b0;
      done_o      <= 1'b0;
      bit_cnt_o   <= 5'd0;
      frame_o     <= '0;
    end else begin
      start_o     <= ncs_fall;
      rise_o      <= sck_rise;
      cmd_valid_o <= sck_fall && (cnt_inc == `CMD_BITS);
      done_o      <= ncs_rise;
      active_o    <= ~ncs_now;
      if (ncs_fall) begin
        bit_cnt_o <= 5'd0;
        frame_o   <= '0;
      end else if (sck_fall) begin
        bit_cnt_o <= cnt_inc;
        if (bit_cnt_o < `CMD_BITS)
          frame_o.cmd  <= {frame_o.cmd[6:0], filt[0]};
        else
          frame_o.data <= {frame_o.data[6:0], filt[0]};
      end
      if (ncs_rise) frame_o.len_ok <= (bit_cnt_o == `FRAME_BITS);
    end
  end

endmodule : spi_frame_rx

// ---- bench/pmic_spi_register_bank_assertions.sv ----
// checker watching the register bank ports
module pmic_spi_register_bank_assertions
  import pmic_regs_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       ncs_i,
  input dev_state_t      dev_state_i,
  input wire logic [3:0] analog_cond_i,
  input wire logic       sdo_o,
  input wire logic       sdo_oe_o,
  input wire logic       enable_drive_or_irq_pin_o,
  input wire logic       enable_drive_control_bit_o,
  input wire logic       safe_request_o,
  input wire logic [7:0] config_checksum_guard_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // ========================================================================
  // helper counters
  logic [3:0] dis_cnt;
  logic [3:0] quiet;
  wire        off_st = dev_state_i inside {ST_OFF, ST_INIT, ST_RESET};
  wire        calm   = ncs_i && analog_cond_i == 4'h0 && dev_state_i != ST_RESET;

  // saturating counts of link-off and undisturbed cycles
  always_ff @(posedge clk_i) begin
    dis_cnt <= (rst_i || !off_st) ? 4'h0 : dis_cnt + {3'h0, dis_cnt != 4'h8};
    quiet   <= (rst_i || !calm) ? 4'h0 : quiet + {3'h0, quiet != 4'h8};
  end

  // ========================================================================
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  reset_link_a: assert property (disable iff (1'b0) rst_i |=> !sdo_oe_o && !sdo_o)
    else $error("link output active after reset");
  reset_pin_a: assert property (disable iff (1'b0) rst_i |=> !enable_drive_or_irq_pin_o)
    else $error("enable pin high in reset");
  default_en_a: assert property ($fell(rst_i) |=> enable_drive_control_bit_o)
    else $error("enable bit default not loaded");
  bit_clear_a: assert property (safe_request_o |-> !enable_drive_control_bit_o)
    else $error("enable bit set during safe request");
  safe_cause_a: assert property (safe_request_o |-> $past(analog_cond_i) != 4'h0)
    else $error("safe request without a condition");
  safe_pin_a: assert property (safe_request_o |-> !enable_drive_or_irq_pin_o)
    else $error("enable pin high during safe request");
  link_off_a: assert property (dis_cnt == 4'h8 |-> !sdo_o)
    else $error("data driven while link disabled");
  idle_oe_a: assert property (ncs_i [*8] |-> !sdo_oe_o)
    else $error("data enabled while deselected");
  crc_hold_a: assert property (quiet == 4'h8 |=> $stable(config_checksum_guard_o))
    else $error("checksum moved without cause");

  cover property (safe_request_o);
  cover property ($rose(sdo_oe_o));
  cover property (dis_cnt == 4'h8);
endmodule : pmic_spi_register_bank_assertions

bind pmic_spi_register_bank pmic_spi_register_bank_assertions i_chk (
  .clk_i, .rst_i, .ncs_i, .dev_state_i, .analog_cond_i, .sdo_o, .sdo_oe_o,
  .enable_drive_or_irq_pin_o, .enable_drive_control_bit_o, .safe_request_o,
  .config_checksum_guard_o
);

// ---- bench/spi_host_model.sv ----
// host side serial master sending one 16-bit frame at a time
module spi_host_model (
  output logic        ncs_o,
  output logic        sck_o,
  output logic        sdi_o,
  input  wire logic   sdo_i,
  input  wire logic   sdo_oe_i,
  output logic [15:0] rx_o,
  output logic        rx_vld_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle: deselected, clock still low
  initial begin
    ncs_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
    rx_o = 16'h0000;
    rx_vld_o = 1'b0;
  end

  // shift out on rising, sample on falling, 125 ns clock period
  task automatic xfer(input logic [7:0] c, input logic [7:0] d);
    logic [15:0] tx;
    tx = {c, d};
    ncs_o = 1'b0;
    #100;
    for (int k = 15; k >= 0; k--) begin
      sck_o = 1'b1;
      sdi_o = tx[k];
      #62.5;
      sck_o = 1'b0;
      rx_o[k] = sdo_oe_i ? sdo_i : ~rx_o[k];
      #62.5;
    end
    ncs_o = 1'b1;
    sdi_o = ~sdi_o; // released line shows no stale level
    rx_vld_o = 1'b1;
    #800;
    rx_vld_o = 1'b0;
  endtask : xfer
endmodule : spi_host_model

// ---- bench/tb_pmic_spi_register_bank.sv ----
// self-checking bench for the register bank with a host link model
`include "pmic_regs_map.svh"
module tb_pmic_spi_register_bank import pmic_regs_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_i, rst_i, cfg_lock_i, ncs, sck, sdi, sdo, sdo_oe, pin, ctl, safe, vld, inv;
  dev_state_t  st;
  dev_state_t  ds [3];
  logic [7:0]  status, crc, m [9], msk [9];
  logic [3:0]  cond;
  logic [15:0] rx, ev_q [$], em_q [$];
  int          errors, num_checks, seed;

  pmic_spi_register_bank i_dut (
    .clk_i, .rst_i, .ncs_i(ncs), .sck_i(sck), .sdi_i(sdi), .dev_state_i(st), .cfg_lock_i,
    .status_i(status), .analog_cond_i(cond), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .enable_drive_or_irq_pin_o(pin), .enable_drive_control_bit_o(ctl),
    .safe_request_o(safe), .config_checksum_guard_o(crc));
  spi_host_model i_host (.ncs_o(ncs), .sck_o(sck), .sdi_o(sdi), .sdo_i(sdo),
    .sdo_oe_i(sdo_oe), .rx_o(rx), .rx_vld_o(vld));

  // ========================================================================
  // checking helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    num_checks++;
    if (seen !== want) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic stop_test();
    if (errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  // checksum over config bytes, first index first, msb first
  function automatic logic [7:0] crc_of();
    logic [7:0] c;
    c = 8'hff;
    for (int i = 3; i < 9; i++)
      for (int b = 7; b >= 0; b--)
        c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i][b]) ? 8'h07 : 8'h00);
    return ~c;
  endfunction : crc_of

  // note the expected answer, then send the frame
  task automatic xf(input logic [7:0] c, input logic [7:0] d, input logic [7:0] e,
                    input logic [7:0] k);
    logic off;
    off = st inside {ST_OFF, ST_INIT, ST_RESET};
    ev_q.push_back(off ? 16'h0000 : {7'h00, inv, e});
    em_q.push_back(off ? 16'hffff : {7'h00, 1'b1, k});
    if (!off)
      inv = !(c[7:4] == 4'h0 && c[3:0] < 4'h9 || c[7:4] == 4'h8 && c[3:0] > 4'h2 && c[3:0] < 4'h9);
    i_host.xfer(c, d);
  endtask : xf

  task automatic rd(input logic [3:0] i);
    xf({4'h0, i}, 8'h00, m[i], msk[i]);
  endtask : rd

  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    if (st == ST_DIAGNOSTIC && !cfg_lock_i && i > 4'h2 && i < 4'h9) begin
      if (i == 4'h8 && (d & msk[8]) != m[8])
        m[6] = 8'h00;
      m[i] = d & msk[i];
    end
    xf({4'h8, i}, d, 8'h00, 8'h00);
  endtask : wr

  // compare each answered frame with the oldest note
  always @(posedge vld) begin
    check(rx & em_q[0], ev_q[0] & em_q[0]);
    void'(ev_q.pop_front());
    void'(em_q.pop_front());
  end

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // watchdog against a hang, about two and a half times the expected run
  initial begin
    #400us;
    errors++;
    stop_test();
  end

  // ========================================================================
  // main sequence
  initial begin
    seed = 80;
    rst_i = 1'b1;
    cfg_lock_i = 1'b0;
    st = ST_DIAGNOSTIC;
    cond = 4'h0;
    inv = 1'b0;
    status = 8'($random(seed));
    ds = '{ST_OFF, ST_INIT, ST_RESET};
    msk = '{`MASK_REVISION, `MASK_IDENTITY, `MASK_STATUS_ONE, `MASK_CONFIG_ONE,
            `MASK_CONFIG_TWO, `MASK_SAFETY_FOUR, `MASK_SAFETY_FIVE, `MASK_EXT_MON_ONE,
            `MASK_WATCHDOG};
    m = '{`RST_REVISION, 8'h02 & `MASK_IDENTITY, status, `RST_CONFIG_ONE, `RST_CONFIG_TWO,
          `RST_SAFETY_FOUR, `RST_SAFETY_FIVE, `RST_EXT_MON_ONE, `RST_WATCHDOG};
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    check(16'(pin), 16'h0001);
    check(16'(crc), 16'(crc_of()));
    for (int i = 0; i < 9; i++)
      rd(4'(i));
    for (int i = 8; i > 2; i--)
      wr(4'(i), 8'($random(seed)));
    for (int i = 0; i < 9; i++)
      rd(4'(i));
    check(16'(ctl), 16'(m[3][0]));
    check(16'(crc), 16'(crc_of()));
    wr(4'h0, 8'h5a);
    rd(4'h0);
    rd(4'h1);
    @(negedge clk_i) cfg_lock_i = 1'b1;
    wr(4'h3, ~m[3]);
    rd(4'h3);
    @(negedge clk_i) cfg_lock_i = 1'b0;
    @(negedge clk_i) st = ST_ACTIVE;
    wr(4'h5, ~m[5]);
    rd(4'h5);
    for (int j = 0; j < 3; j++) begin
      @(negedge clk_i) st = ds[j];
      rd(4'h0);
      wr(4'h3, ~m[3]);
    end
    @(negedge clk_i) st = ST_DIAGNOSTIC;
    inv = 1'b0;
    m[5] = `RST_SAFETY_FOUR;
    m[6] = `RST_SAFETY_FIVE;
    for (int i = 2; i < 9; i++)
      rd(4'(i));
    wr(4'h6, 8'ha5);
    wr(4'h8, m[8]);
    rd(4'h6);
    wr(4'h8, m[8] ^ 8'h01);
    rd(4'h6);
    wr(4'h4, 8'h01);
    wr(4'h3, 8'h01);
    @(negedge clk_i) cond = 4'he;
    repeat (3) @(negedge clk_i);
    check({14'h0, pin, safe}, 16'h0002);
    cond = 4'h1;
    repeat (3) @(negedge clk_i);
    check({13'h0, pin, ctl, safe}, 16'h0001);
    cond = 4'h0;
    m[3][0] = 1'b0;
    rd(4'h3);
    check(16'(crc), 16'(crc_of()));
    wr(4'h3, 8'h01);
    check(16'(pin), 16'h0001);
    stop_test();
  end
endmodule : tb_pmic_spi_register_bank
